// file: verilog/switch_global_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts for the global control block
// Assumes: 8-bit registers on the management serial port, 100 MHz core clock
// Notes:   every figure used by the design lives here
`ifndef SWITCH_GLOBAL_CFG_SVH
`define SWITCH_GLOBAL_CFG_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define ADDR_VLAN_IGMP_QUEUE_SNIFF 8'h05
`define ADDR_MII_PORT_STORM_RATE   8'h06
`define ADDR_STORM_RATE_LOW        8'h07

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define BIT_VLAN_ENABLE      3'd7
`define BIT_IGMP_SNOOP       3'd6
`define BIT_WFQ_ENABLE       3'd3
`define BIT_SNIFF_AND        3'd0
`define BIT_MII_HALF_DUPLEX  3'd6
`define BIT_MII_FLOW_CTRL    3'd5
`define BIT_MII_10MBPS       3'd4
`define BIT_NULL_VID_REPLACE 3'd3

// writable bits; all others read back their reset value
`define MASK_CTRL3_RW        8'hc9
`define MASK_CTRL4_RW        8'h7f

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RESET_CTRL3          8'h00
`define RESET_STORM_HIGH     3'h0
`define RESET_STORM_LOW      8'h63

// ----------------------------------------------------------------------------
// storm period timing
// ----------------------------------------------------------------------------
`define CLOCK_MHZ            100
`define STORM_PERIOD_FAST_MS 67
`define STORM_PERIOD_SLOW_MS 500
`define STORM_FAST_CYCLES    (`STORM_PERIOD_FAST_MS * 1000 * `CLOCK_MHZ)
`define STORM_SLOW_CYCLES    (`STORM_PERIOD_SLOW_MS * 1000 * `CLOCK_MHZ)

// ----------------------------------------------------------------------------
// weighted fair queue weights for q3..q0
// ----------------------------------------------------------------------------
`define WFQ_WEIGHT_Q3        4'd8
`define WFQ_WEIGHT_Q2        4'd4
`define WFQ_WEIGHT_Q1        4'd2
`define WFQ_WEIGHT_Q0        4'd1

`endif

// file: verilog/switch_global_pkg.sv
// Purpose: types shared by the global control block
// Assumes: constants come from switch_global_cfg.svh
// Notes:   state of the block is one packed struct
package switch_global_pkg;

  typedef struct packed {
    logic [7:0]  ctrl3;
    logic [7:0]  ctrl4;
    logic [7:0]  storm_low;
    logic [1:0]  queue;
    logic [3:0]  credit;
    logic [31:0] period_count;
    logic        period_tick;
    logic        started;
  } state_t;

endpackage : switch_global_pkg

// file: verilog/switch_global_control.sv
// Purpose: global control registers 3 and 4 and the behaviour they select
// Assumes: register port is the device's management serial port, already decoded into bytes
// Notes:   strap pins are sampled on the first clock after reset release
//          reg_rdata is combinational; unmapped offsets read zero
`timescale 1ns/1ps
`default_nettype none
`include "switch_global_cfg.svh"

module switch_global_control #(
  parameter int unsigned STORM_FAST_CYCLES = `STORM_FAST_CYCLES,
  parameter int unsigned STORM_SLOW_CYCLES = `STORM_SLOW_CYCLES
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // strap pins
  input  wire logic        duplex_strap_pin,
  input  wire logic        flow_ctrl_strap_pin,
  input  wire logic        mii_speed_strap_pin,
  // management register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_write,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // forwarding decisions
  input  wire logic        frame_is_igmp,
  input  wire logic        frame_vid_null,
  input  wire logic [11:0] frame_vid,
  input  wire logic [11:0] port_vid,
  output logic             vlan_mode,
  output logic             igmp_to_mii,
  output logic      [11:0] egress_vid,
  // sniffer
  input  wire logic        sniff_src_match,
  input  wire logic        sniff_dst_match,
  output logic             sniff_mirror,
  // egress scheduling
  input  wire logic [2:0]  port_prio_bit7,
  input  wire logic [3:0]  queue_busy,
  input  wire logic        queue_sent,
  output logic             wfq_mode,
  output logic      [2:0]  port_strict_prio,
  output logic      [1:0]  queue_grant,
  output logic             queue_grant_valid,
  // port 3 mii configuration
  output logic             mii_half_duplex,
  output logic             mii_flow_ctrl,
  output logic             mii_10mbps,
  // storm protection
  output logic      [10:0] storm_limit,
  output logic             storm_period_tick
);

  switch_global_pkg::state_t state;
  switch_global_pkg::state_t next_state;

  // helpers of the weighted round and the storm window, all combinational
  logic [31:0] period_len;
  logic [3:0]  weight_sel;
  logic [1:0]  top_busy;
  logic [1:0]  next_queue;
  logic [1:0]  pick;
  logic        found;

  // ----------------------------------------------------------------------------
  // weight of the current queue, with the empty queues' spare unit
  // ----------------------------------------------------------------------------
  always_comb begin
    // highest queue holding packets, q0 when all are empty
    top_busy = 2'd0;
    for (int i = 0; i < 4; i++) begin
      if (queue_busy[i]) begin
        top_busy = 2'(i);
      end
    end
    unique case (state.queue)
      2'd3: weight_sel = `WFQ_WEIGHT_Q3;
      2'd2: weight_sel = `WFQ_WEIGHT_Q2;
      2'd1: weight_sel = `WFQ_WEIGHT_Q1;
      2'd0: weight_sel = `WFQ_WEIGHT_Q0;
    endcase
    // spare unit only while some queue is empty, and only for the top busy one
    if (queue_busy != 4'hf && state.queue == top_busy) begin
      weight_sel = weight_sel + 4'd1;
    end
    // next busy queue going downward, wrapping to the top
    found = 1'b0;
    pick  = state.queue;
    for (int k = 1; k <= 4; k++) begin
      next_queue = 2'(state.queue - 2'(k));
      if (!found && queue_busy[next_queue]) begin
        found = 1'b1;
        pick  = next_queue;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb begin
    next_state             = state;
    next_state.period_tick = 1'b0;
    if (!state.started) begin
      // straps caught once after release, never under the reset itself
      next_state.started               = 1'b1;
      next_state.ctrl4[`BIT_MII_HALF_DUPLEX] = duplex_strap_pin;
      next_state.ctrl4[`BIT_MII_FLOW_CTRL]   = flow_ctrl_strap_pin;
      next_state.ctrl4[`BIT_MII_10MBPS]      = mii_speed_strap_pin;
    end else if (reg_write) begin
      // reserved bits are rebuilt from their defaults, never from write data
      unique case (reg_addr)
        `ADDR_VLAN_IGMP_QUEUE_SNIFF: next_state.ctrl3 =
            (reg_wdata & `MASK_CTRL3_RW) | (`RESET_CTRL3 & ~`MASK_CTRL3_RW);
        `ADDR_MII_PORT_STORM_RATE:   next_state.ctrl4 = reg_wdata & `MASK_CTRL4_RW;
        `ADDR_STORM_RATE_LOW:        next_state.storm_low = reg_wdata;
        default: ;
      endcase
    end
    // storm measurement window follows the mii speed
    // a speed change mid window stretches or cuts only that one window
    period_len = state.ctrl4[`BIT_MII_10MBPS] ? STORM_SLOW_CYCLES : STORM_FAST_CYCLES;
    if (state.period_count >= period_len - 32'd1) begin
      next_state.period_count = 32'd0;
      next_state.period_tick  = 1'b1;
    end else begin
      next_state.period_count = state.period_count + 32'd1;
    end
    // weighted round: stay on a queue until its credit is spent
    // credit counts packets, not bytes: long frames cost what short ones do
    // a queue that empties gives up its turn; unused credit is not kept
    if (!state.ctrl3[`BIT_WFQ_ENABLE] || queue_busy == 4'h0) begin
      // parked on the top busy queue so enabling wfq starts the round there
      next_state.credit = 4'd0;
      next_state.queue  = top_busy;
    end else if (!queue_busy[state.queue]) begin
      next_state.queue  = pick;
      next_state.credit = 4'd0;
    end else if (queue_sent) begin
      if (state.credit + 4'd1 >= weight_sel) begin
        next_state.credit = 4'd0;
        next_state.queue  = pick;
      end else begin
        next_state.credit = state.credit + 4'd1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------------
  // sync reset restores register defaults; straps wait for the started cycle
  // so a strap still settling under reset is never latched
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state           <= '0;
      state.ctrl3     <= `RESET_CTRL3;
      state.storm_low <= `RESET_STORM_LOW;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------------------
  always_comb begin
    unique case (reg_addr)
      `ADDR_VLAN_IGMP_QUEUE_SNIFF: reg_rdata = state.ctrl3;
      `ADDR_MII_PORT_STORM_RATE:   reg_rdata = state.ctrl4;
      `ADDR_STORM_RATE_LOW:        reg_rdata = state.storm_low;
      // the host sees a write on the cycle after its write edge
      default:                     reg_rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------------
  // forwarding and scheduling decisions
  // ----------------------------------------------------------------------------
  assign vlan_mode         = state.ctrl3[`BIT_VLAN_ENABLE];
  assign igmp_to_mii       = state.ctrl3[`BIT_IGMP_SNOOP] & frame_is_igmp;
  assign egress_vid        = (state.ctrl4[`BIT_NULL_VID_REPLACE] && frame_vid_null) ? port_vid : frame_vid;
  assign sniff_mirror      = state.ctrl3[`BIT_SNIFF_AND] ? (sniff_src_match & sniff_dst_match)
                                                         : (sniff_src_match | sniff_dst_match);
  assign wfq_mode          = state.ctrl3[`BIT_WFQ_ENABLE];
  // ports lose strict priority while wfq owns the egress scheduler
  assign port_strict_prio  = state.ctrl3[`BIT_WFQ_ENABLE] ? 3'h0 : port_prio_bit7;
  assign queue_grant       = state.queue;
  assign queue_grant_valid = state.ctrl3[`BIT_WFQ_ENABLE] & queue_busy[state.queue];

  // ----------------------------------------------------------------------------
  // port 3 mii and storm protection
  // ----------------------------------------------------------------------------
  assign mii_half_duplex   = state.ctrl4[`BIT_MII_HALF_DUPLEX];
  assign mii_flow_ctrl     = state.ctrl4[`BIT_MII_FLOW_CTRL];
  assign mii_10mbps        = state.ctrl4[`BIT_MII_10MBPS];
  // the low storm byte sits at the next offset but still feeds this limit
  assign storm_limit       = {state.ctrl4[2:0], state.storm_low};
  assign storm_period_tick = state.period_tick;

endmodule : switch_global_control

`default_nettype wire

// file: sim/switch_global_chk.sv
// Purpose: port assertions for switch_global_control
// Assumes: reg_rdata shows the addressed register in the same cycle
// Notes:   $past(rst_n) skips the strap edge, where writes are dropped
`timescale 1ns/1ps
`default_nettype none
module switch_global_chk (
  input wire logic        clock, rst_n, reg_write, frame_is_igmp, igmp_to_mii, sniff_src_match,
  input wire logic        sniff_dst_match, sniff_mirror, wfq_mode, vlan_mode, queue_sent, storm_period_tick,
  input wire logic [7:0]  reg_addr, reg_wdata, reg_rdata,
  input wire logic [2:0]  port_prio_bit7, port_strict_prio,
  input wire logic [10:0] storm_limit
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic w5;
  assign w5 = reg_write && reg_addr == 8'h05;
  a_vlan_on_write: assert property ($past(rst_n) && w5 |=> vlan_mode == $past(reg_wdata[7]))
    else $error("vlan mode does not follow write");
  a_wfq_on_write: assert property ($past(rst_n) && w5 |=> wfq_mode == $past(reg_wdata[3]))
    else $error("wfq mode does not follow write");
  a_igmp_to_mii: assert property (reg_addr == 8'h05 |-> igmp_to_mii == (reg_rdata[6] && frame_is_igmp))
    else $error("igmp forward wrong");
  a_sniff_match: assert property (reg_addr == 8'h05 |-> sniff_mirror ==
    (reg_rdata[0] ? (sniff_src_match && sniff_dst_match) : (sniff_src_match || sniff_dst_match)))
    else $error("sniff mirror wrong");
  a_strict_prio: assert property (port_strict_prio == (wfq_mode ? 3'h0 : port_prio_bit7))
    else $error("strict priority wrong");
  a_storm_high: assert property (reg_addr == 8'h06 |-> storm_limit[10:8] == reg_rdata[2:0])
    else $error("storm limit high bits wrong");
  a_ctrl3_reserved: assert property (reg_addr == 8'h05 |-> (reg_rdata & 8'h36) == 8'h00)
    else $error("ctrl3 reserved bits set");
  a_ctrl4_reserved: assert property (reg_addr == 8'h06 |-> !reg_rdata[7])
    else $error("ctrl4 reserved bit set");
  a_unmapped_zero: assert property (reg_addr > 8'h07 |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  c_write: cover property (w5);
  c_sent: cover property (queue_sent);
  c_tick: cover property (storm_period_tick);
  c_wfq_sent: cover property (wfq_mode && queue_sent);
endmodule : switch_global_chk
bind switch_global_control switch_global_chk u_chk (.*);
`default_nettype wire

// file: sim/mii_host_model.sv
// Purpose: host side of the port 3 mii, drains the granted queue
// Assumes: one pulse on sent per packet taken
// Notes:   slow leaves four idle cycles between packets
`timescale 1ns/1ps
`default_nettype none
module mii_host_model (
  input  wire logic clock, rst_n, grant_valid, slow,
  output var logic  sent
);
  logic [1:0] gap;
  always_ff @(posedge clock) begin
    if (!rst_n || sent) begin
      sent <= 1'b0;
      gap  <= (rst_n && slow) ? 2'd3 : 2'd0;
    end else if (gap != 2'd0) begin
      gap <= gap - 2'd1;
    end else begin
      sent <= grant_valid;
    end
  end
endmodule : mii_host_model
`default_nettype wire

// file: sim/tb_switch_global_control.sv
// Purpose: self-checking bench for switch_global_control
// Assumes: storm periods shortened to 20 and 50 cycles
// Notes:   queue traffic comes from mii_host_model
`timescale 1ns/1ps
`default_nettype none
module tb_switch_global_control;
  logic        clock, rst_n, duplex_strap_pin, flow_ctrl_strap_pin, mii_speed_strap_pin, reg_write;
  logic        frame_is_igmp, frame_vid_null, sniff_src_match, sniff_dst_match, queue_sent, slow;
  logic        vlan_mode, igmp_to_mii, sniff_mirror, wfq_mode, queue_grant_valid, mii_half_duplex;
  logic        mii_flow_ctrl, mii_10mbps, storm_period_tick;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [11:0] frame_vid, port_vid, egress_vid;
  logic [2:0]  port_prio_bit7, port_strict_prio;
  logic [3:0]  queue_busy;
  logic [1:0]  queue_grant;
  logic [10:0] storm_limit;
  int          err_total, cmp_count, cycles, total, n;
  int          sends [4];

  switch_global_control #(.STORM_FAST_CYCLES(20), .STORM_SLOW_CYCLES(50)) u_dut (.*);
  mii_host_model u_host (.clock, .rst_n, .grant_valid(queue_grant_valid), .slow, .sent(queue_sent));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (queue_sent && queue_grant_valid) begin
      sends[queue_grant]++;
      total++;
    end
    if (cycles == 20000) begin
      err_total++;
      conclude();
    end
  end

  task automatic conclude;
    $display("mismatches %0d of %0d checks", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [11:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, exp);
    @(posedge clock);
    reg_addr <= a;
    @(posedge clock);
    #1;
    chk("reg_rdata", reg_rdata, exp);
  endtask : rd

  task automatic rst(input logic [2:0] straps);
    @(posedge clock);
    rst_n <= 1'b0;
    {duplex_strap_pin, flow_ctrl_strap_pin, mii_speed_strap_pin} <= straps;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
  endtask : rst

  task automatic s_straps_and_regs;
    rst(3'b101);
    rd(8'h06, 8'h50);
    rst(3'b010);
    rd(8'h06, 8'h20);
    rd(8'h07, 8'h63);
    wr(8'h05, 8'hff);
    rd(8'h05, 8'hc9);
    chk("vlan_mode", vlan_mode, 1'b1);
    wr(8'h06, 8'hff);
    wr(8'h07, 8'ha5);
    rd(8'h06, 8'h7f);
    chk("storm_limit", storm_limit, 11'h7a5);
    chk("mii", {mii_half_duplex, mii_flow_ctrl, mii_10mbps}, 3'h7);
    wr(8'h09, 8'hff);
    rd(8'h09, 8'h00);
    wr(8'h05, 8'h00);
    rd(8'h05, 8'h00);
    chk("vlan_mode", vlan_mode, 1'b0);
  endtask : s_straps_and_regs

  task automatic s_forward;
    for (int m = 0; m < 2; m++) begin
      wr(8'h05, m ? 8'h41 : 8'h00);
      wr(8'h06, m ? 8'h08 : 8'h00);
      for (int k = 0; k < 4; k++) begin
        @(posedge clock);
        {frame_vid_null, frame_is_igmp} <= k[1:0];
        {sniff_src_match, sniff_dst_match} <= k[1:0];
        @(posedge clock);
        #1;
        chk("mirror", sniff_mirror, m ? k == 3 : k != 0);
        chk("igmp", igmp_to_mii, m && k[0]);
        chk("vid", egress_vid, (m && k[1]) ? 12'h456 : 12'h123);
      end
    end
  endtask : s_forward

  task automatic s_prio;
    @(posedge clock);
    port_prio_bit7 <= 3'b101;
    queue_busy     <= 4'b0110;
    rd(8'h05, 8'h41);
    chk("wfq_mode", wfq_mode, 1'b0);
    chk("strict", port_strict_prio, 3'b101);
    chk("grant", {queue_grant_valid, queue_grant}, 3'b010);
    wr(8'h05, 8'h08);
    rd(8'h05, 8'h08);
    chk("wfq_mode", wfq_mode, 1'b1);
    chk("strict", port_strict_prio, 3'b000);
  endtask : s_prio

  task automatic s_wfq(input logic [3:0] busy, input logic sl, input logic [15:0] w, input int sum);
    rst(3'b010);
    queue_busy <= busy;
    slow       <= sl;
    sends = '{0, 0, 0, 0};
    total = 0;
    wr(8'h05, 8'h08);
    while (total < sum)
      @(posedge clock);
    for (int q = 0; q < 4; q++) chk("sends", sends[q], w[4*q +: 4]);
  endtask : s_wfq

  task automatic period(input int exp);
    @(posedge clock iff storm_period_tick);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (!storm_period_tick);
    chk("period", n, exp);
  endtask : period

  task automatic s_storm;
    rst(3'b010);
    period(20);
    wr(8'h06, 8'h10);
    @(posedge clock iff storm_period_tick);
    period(50);
  endtask : s_storm

  initial begin
    {rst_n, reg_write, frame_is_igmp, frame_vid_null, sniff_src_match, sniff_dst_match, slow} = '0;
    {duplex_strap_pin, flow_ctrl_strap_pin, mii_speed_strap_pin} = 3'b010;
    {reg_addr, reg_wdata, port_prio_bit7, queue_busy} = '0;
    frame_vid = 12'h123;
    port_vid  = 12'h456;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    s_straps_and_regs();
    s_forward();
    s_prio();
    s_wfq(4'b1111, 1'b0, 16'h8421, 15);
    s_wfq(4'b1011, 1'b1, 16'h9021, 12);
    s_storm();
    conclude();
  end
endmodule : tb_switch_global_control
`default_nettype wire
